// ---- hdl/pfd_pkg.sv ----
/*
   pfd_pkg: constants and carrier types for the programmable frequency divider.
   assumes: included before every design file of the divider; no timescale here.
*/
package pfd_pkg;

   // counter and select geometry
   localparam int unsigned PFD_CNT_W = 10;
   localparam int unsigned PFD_SEL_W = 4;
   localparam logic [PFD_SEL_W-1:0] PFD_SEL_MAX = 4'h9;
   localparam int unsigned PFD_SYNC_STAGES = 2;

   // apb geometry
   localparam int unsigned PFD_ADDR_W = 12;
   localparam int unsigned PFD_DATA_W = 32;
   localparam int unsigned PFD_STRB_W = 4;

   // register byte offsets
   localparam logic [PFD_ADDR_W-1:0] PFD_OFF_CTRL = 12'h000;
   localparam logic [PFD_ADDR_W-1:0] PFD_OFF_STATUS = 12'h004;
   localparam logic [PFD_ADDR_W-1:0] PFD_OFF_WRAPS = 12'h008;
   localparam logic [PFD_ADDR_W-1:0] PFD_OFF_EVENT = 12'h00c;

   // ctrl fields: bit 0 source, bits 7:4 software select code
   localparam int unsigned PFD_CTRL_SRC_BIT = 0;
   localparam int unsigned PFD_CTRL_SEL_LSB = 4;

   // event fields, write one to clear
   localparam int unsigned PFD_EVT_SEL_BIT = 0;
   localparam int unsigned PFD_EVT_WRAP_BIT = 1;
   localparam int unsigned PFD_EVT_W = 2;

   // wrap counter width
   localparam int unsigned PFD_WRAP_W = 16;

   // reset values
   localparam logic [PFD_CNT_W-1:0] PFD_CNT_RESET = 10'h000;
   localparam logic [PFD_SEL_W-1:0] PFD_SEL_RESET = 4'h0;
   localparam logic [PFD_WRAP_W-1:0] PFD_WRAP_RESET = 16'h0000;
   localparam logic [PFD_EVT_W-1:0] PFD_EVT_RESET = 2'h0;
   localparam logic [PFD_DATA_W-1:0] PFD_DATA_ZERO = 32'h0000_0000;

   // software control carrier
   typedef struct packed {
      logic [PFD_SEL_W-1:0] sw_sel;
      logic sw_src;
   } pfd_ctrl_t;

   // status carrier, read in the low 16 bits of status
   typedef struct packed {
      logic code_invalid;
      logic [PFD_SEL_W-1:0] sel;
      logic div_out;
      logic [PFD_CNT_W-1:0] count;
   } pfd_status_t;

   localparam pfd_ctrl_t PFD_CTRL_RESET = '{sw_sel: 4'h0, sw_src: 1'b0};

endpackage : pfd_pkg

// ---- hdl/pfd_sync.sv ----
/*
   pfd_sync: two-stage synchroniser for a bundle of slowly changing pin levels.
   assumes: the bits are quasi-static; a bundle that changes in one edge may
   land over two cycles, which downstream logic must tolerate.
*/
`timescale 1ns/10ps
`default_nettype none

module pfd_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end

endmodule : pfd_sync

`default_nettype wire

// ---- hdl/pfd_count_cell.sv ----
/*
   pfd_count_cell: one bit of the binary up-counter, a toggle cell.
   assumes: i_carry is high exactly when every lower bit is one (tie high for
   bit 0); carries ripple combinationally through the chain.
*/
`timescale 1ns/10ps
`default_nettype none

module pfd_count_cell (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_carry,
   output logic o_q,
   output logic o_carry
);

   // carry onward only when this bit is also one
   assign o_carry = i_carry & o_q;

   // toggle on carry, so all ones wraps to zero
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_q <= 1'b0;
      end else begin
         o_q <= o_q ^ i_carry;
      end
   end

endmodule : pfd_count_cell

`default_nettype wire

// ---- hdl/pfd_divider.sv ----
/*
   pfd_divider: programmable power-of-two frequency divider with an apb slave.
   assumes: i_clk is the clock to divide; i_ratio_select comes from pins and is
   static in normal use; the apb master follows the usual setup/access phases.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
// Contract
// - ten-bit binary counter increments every rising edge, wrapping all ones to zero.
// - division by powers of two, up to 1024 from the top counter bit.
// - four-bit select code from outside chooses which counter bit reaches the output.
// - select code zero drives the output from counter bit 0, half frequency.
// - select code read unsigned 0 to 9, bit 0 least significant, picks bit n.
// - code 1001 selects the most significant counter bit, lowest frequency.
// - divided output comes from its own single flip-flop, apart from counter cells.
`timescale 1ns/10ps
`default_nettype none

module pfd_divider (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [pfd_pkg::PFD_SEL_W-1:0] i_ratio_select,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [pfd_pkg::PFD_ADDR_W-1:0] i_paddr,
   input wire logic [pfd_pkg::PFD_DATA_W-1:0] i_pwdata,
   input wire logic [pfd_pkg::PFD_STRB_W-1:0] i_pstrb,
   output logic [pfd_pkg::PFD_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_divided_clock_out,
   output logic [pfd_pkg::PFD_CNT_W-1:0] o_count_bits
);
   import pfd_pkg::*;

   // counter chain
   logic [PFD_CNT_W:0] carry_chain;
   logic [PFD_CNT_W-1:0] count_bits;

   // select path
   logic [PFD_SEL_W-1:0] pin_sel_sync;
   logic [PFD_SEL_W-1:0] eff_sel;
   logic sel_valid;
   logic [2*PFD_SEL_W*2-1:0] count_ext;
   logic div_next;
   logic div_reg;

   // software state
   pfd_ctrl_t ctrl_reg;
   pfd_ctrl_t ctrl_next;
   logic [PFD_SEL_W-1:0] sel_prev_reg;
   logic sel_changed;
   logic counter_wraps;
   logic [PFD_WRAP_W-1:0] wraps_reg;
   logic [PFD_WRAP_W-1:0] wraps_next;
   logic [PFD_EVT_W-1:0] event_reg;
   logic [PFD_EVT_W-1:0] event_next;
   logic [PFD_EVT_W-1:0] event_set;
   logic [PFD_EVT_W-1:0] event_clr;
   pfd_status_t status_now;

   // apb decode
   logic apb_access;
   logic apb_commit;
   logic wr_commit;
   logic hit_ctrl;
   logic hit_status;
   logic hit_wraps;
   logic hit_event;
   logic addr_hit;
   logic low_lane;
   logic [PFD_DATA_W-1:0] read_mux;
   logic pready_next;
   logic pslverr_next;
   logic [PFD_DATA_W-1:0] prdata_next;

   // pin select passes two flops before any logic sees it
   pfd_sync #(
      .WIDTH(PFD_SEL_W)
   ) u_sel_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(i_ratio_select),
      .o_sync(pin_sel_sync)
   );

   // counter: one toggle cell per bit, carry ripples up the chain
   assign carry_chain[0] = 1'b1;
   genvar gi;
   generate
      for (gi = 0; gi < PFD_CNT_W; gi++) begin : g_cell
         pfd_count_cell u_cell (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_carry(carry_chain[gi]),
            .o_q(count_bits[gi]),
            .o_carry(carry_chain[gi+1])
         );
      end
   endgenerate

   // all ones now means zero at the next edge
   assign counter_wraps = carry_chain[PFD_CNT_W];

   // software may override the pins; pins rule after reset
   assign eff_sel = ctrl_reg.sw_src ? ctrl_reg.sw_sel : pin_sel_sync;

   // code taken as unsigned n, bit 0 least significant; 0..9 map to a bit
   assign sel_valid = (eff_sel <= PFD_SEL_MAX);

   // widen so every code indexes something; the guard keeps 10..15 off the bits
   assign count_ext = {{(2*PFD_SEL_W*2-PFD_CNT_W){1'b0}}, count_bits};

   // code 0 gives bit 0 (half rate), code 9 gives bit 9 (divide by 1024)
   assign div_next = sel_valid ? count_ext[eff_sel] : 1'b0;

   // the output owns one flop of its own, one cycle behind the counter
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         div_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
      end
   end

   // change detect on the code actually in use
   assign sel_changed = (eff_sel != sel_prev_reg);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sel_prev_reg <= PFD_SEL_RESET;
      end else begin
         sel_prev_reg <= eff_sel;
      end
   end

   // wrap count saturates rather than rolls, so software sees "many"
   assign wraps_next = (counter_wraps && (wraps_reg != {PFD_WRAP_W{1'b1}}))
                       ? wraps_reg + 16'h0001 : wraps_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wraps_reg <= PFD_WRAP_RESET;
      end else if (wr_commit && hit_wraps) begin
         wraps_reg <= PFD_WRAP_RESET;
      end else begin
         wraps_reg <= wraps_next;
      end
   end

   // apb phase decode: access is psel and penable together
   assign apb_access = i_psel & i_penable;
   assign apb_commit = apb_access & o_pready;
   assign wr_commit = apb_commit & i_pwrite & addr_hit;
   assign low_lane = i_pstrb[0];

   // address decode, full word compare so unaligned offsets miss
   assign hit_ctrl = (i_paddr == PFD_OFF_CTRL);
   assign hit_status = (i_paddr == PFD_OFF_STATUS);
   assign hit_wraps = (i_paddr == PFD_OFF_WRAPS);
   assign hit_event = (i_paddr == PFD_OFF_EVENT);
   assign addr_hit = hit_ctrl | hit_status | hit_wraps | hit_event;

   // control register, written through the low byte lane only
   assign ctrl_next = (wr_commit && hit_ctrl && low_lane)
      ? '{sw_sel: i_pwdata[PFD_CTRL_SEL_LSB +: PFD_SEL_W],
          sw_src: i_pwdata[PFD_CTRL_SRC_BIT]}
      : ctrl_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_reg <= PFD_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // sticky events; a new event in the clear cycle survives the clear
   assign event_set[PFD_EVT_SEL_BIT] = sel_changed;
   assign event_set[PFD_EVT_WRAP_BIT] = counter_wraps;
   assign event_clr = (wr_commit && hit_event && low_lane)
                      ? i_pwdata[PFD_EVT_W-1:0] : PFD_EVT_RESET;
   assign event_next = (event_reg & ~event_clr) | event_set;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         event_reg <= PFD_EVT_RESET;
      end else begin
         event_reg <= event_next;
      end
   end

   // live view of the divider
   assign status_now = '{code_invalid: ~sel_valid,
                         sel: eff_sel,
                         div_out: div_reg,
                         count: count_bits};

   // read data, zero above each register's width
   assign read_mux = hit_ctrl ? {{(PFD_DATA_W-PFD_CTRL_SEL_LSB-PFD_SEL_W){1'b0}},
                                 ctrl_reg.sw_sel, 3'h0, ctrl_reg.sw_src}
                   : hit_status ? {{(PFD_DATA_W-$bits(pfd_status_t)){1'b0}}, status_now}
                   : hit_wraps ? {{(PFD_DATA_W-PFD_WRAP_W){1'b0}}, wraps_reg}
                   : hit_event ? {{(PFD_DATA_W-PFD_EVT_W){1'b0}}, event_reg}
                   : PFD_DATA_ZERO;

   // one wait state: ready rises the cycle after access starts, for one cycle
   assign pready_next = apb_access & ~o_pready;
   assign pslverr_next = pready_next & ~addr_hit;
   assign prdata_next = (pready_next && !i_pwrite) ? read_mux : PFD_DATA_ZERO;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= PFD_DATA_ZERO;
      end else begin
         o_pready <= pready_next;
         o_pslverr <= pslverr_next;
         o_prdata <= prdata_next;
      end
   end

   // outputs straight from flops
   assign o_divided_clock_out = div_reg;
   assign o_count_bits = count_bits;

endmodule : pfd_divider

`default_nettype wire

// ---- hdl/pfd_divider_end.sv ----
/*
   pfd_divider_end: holds no logic; the divider lives in pfd_divider.sv.
*/

// ---- tb/pfd_divider_assertions.sv ----
/* pfd_divider_assertions: port-level checks of the frequency divider.
   assumes: bound to pfd_divider; ctrl writes are seen as apb commits. */
`timescale 1ns/10ps
`default_nettype none
module pfd_divider_assertions (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [pfd_pkg::PFD_SEL_W-1:0] i_ratio_select,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [pfd_pkg::PFD_ADDR_W-1:0] i_paddr,
   input wire logic [pfd_pkg::PFD_DATA_W-1:0] i_pwdata,
   input wire logic [pfd_pkg::PFD_STRB_W-1:0] i_pstrb,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_divided_clock_out,
   input wire logic [pfd_pkg::PFD_CNT_W-1:0] o_count_bits
);
   import pfd_pkg::*;
   logic [3:0] pin1_reg, pin2_reg, sw_reg;
   logic src_reg;
   wire logic [3:0] eff = src_reg ? sw_reg : pin2_reg;
   wire logic exp_bit = (eff <= PFD_SEL_MAX) ? o_count_bits[eff] : 1'b0;
   wire logic ctrl_wr = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0]
      & (i_paddr == PFD_OFF_CTRL);
   // mirror of pin synchroniser and ctrl, so the effective code is exact
   always_ff @(posedge i_clk) begin
      pin1_reg <= i_rst ? 4'h0 : i_ratio_select;
      pin2_reg <= i_rst ? 4'h0 : pin1_reg;
      src_reg <= i_rst ? 1'b0 : (ctrl_wr ? i_pwdata[0] : src_reg);
      sw_reg <= i_rst ? 4'h0 : (ctrl_wr ? i_pwdata[7:4] : sw_reg);
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_code0_held;
      eff == 4'h0 [*3];
   endsequence
   chk_count_step: assert property (1'b1 |=> o_count_bits == $past(o_count_bits) + 10'h1)
      else $error("counter did not step by one");
   chk_count_wrap: assert property (o_count_bits == 10'h3ff |=> o_count_bits == 10'h000)
      else $error("counter did not wrap to zero");
   chk_code_zero: assert property (s_code0_held |-> o_divided_clock_out != $past(o_divided_clock_out))
      else $error("code zero output did not toggle");
   chk_code_top: assert property (eff == 4'h9 |=> o_divided_clock_out == $past(o_count_bits[9]))
      else $error("code nine output not from top bit");
   chk_div_follow: assert property (1'b1 |=> o_divided_clock_out == $past(exp_bit))
      else $error("output not the selected bit");
   chk_bad_low: assert property (eff > PFD_SEL_MAX |=> !o_divided_clock_out)
      else $error("invalid code output not low");
   chk_out_lag: assert property ($changed(exp_bit) |=> $changed(o_divided_clock_out))
      else $error("output flop missed a change");
   chk_ready_pulse: assert property (o_pready |=> !o_pready && !o_pslverr)
      else $error("pready held over one cycle");
endmodule : pfd_divider_assertions
bind pfd_divider pfd_divider_assertions chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_ratio_select(i_ratio_select), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
   .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_divided_clock_out(o_divided_clock_out), .o_count_bits(o_count_bits));
`default_nettype wire

// ---- tb/pfd_sel_source.sv ----
/* pfd_sel_source: outside party driving the four select pins.
   assumes: the bench asks for a code; pins move just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module pfd_sel_source (
   input wire logic i_clk,
   input wire logic [3:0] i_code,
   output logic [3:0] o_ratio_select
);
   initial o_ratio_select = 4'h0;
   // quasi-static levels, only ever changed right after an edge
   always @(posedge i_clk) begin
      o_ratio_select <= i_code;
   end
endmodule : pfd_sel_source
`default_nettype wire

// ---- tb/pfd_divider_tb.sv ----
/* pfd_divider_tb: self-checking bench for the frequency divider.
   assumes: package, design, partner model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected at %0t: %h vs %h", $time, got, exp); end end
module pfd_divider_tb;
   import pfd_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, src = 1'b0, chk_on = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'h0, code = 4'h0, pins, sw = 4'h0, c1, c2;
   logic [9:0] cnt, ref_cnt;
   logic pready, pslverr, div_out, exp_q;
   int num_errors = 0, n_compared = 0;
   wire logic [3:0] eff = src ? sw : c2;
   always #2 i_clk = ~i_clk;
   function automatic logic exp_bit(input logic [9:0] c, input logic [3:0] s);
      return (s <= PFD_SEL_MAX) ? c[s] : 1'b0;
   endfunction : exp_bit
   // reference counter, pin synchroniser mirror and expected output
   always @(posedge i_clk) begin
      ref_cnt <= i_rst ? 10'h000 : ref_cnt + 10'h001;
      c1 <= i_rst ? 4'h0 : pins;
      c2 <= i_rst ? 4'h0 : c1;
      exp_q <= i_rst ? 1'b0 : exp_bit(ref_cnt, eff);
   end
   // falling edge: every output has settled
   always @(negedge i_clk) begin
      if (chk_on) begin
         `CHK(cnt, ref_cnt)
         `CHK(div_out, exp_q)
      end
   end
   pfd_sel_source src_u (.i_clk(i_clk), .i_code(code), .o_ratio_select(pins));
   pfd_divider dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ratio_select(pins), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_divided_clock_out(div_out), .o_count_bits(cnt));
   task automatic give_verdict();
      $display("errors %0d, compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge i_clk);
      penable <= 1'b1;
      // sample ready at the rising edge; the values read are those that stood
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (wr && a == PFD_OFF_CTRL && s[0]) begin
         src <= d[PFD_CTRL_SRC_BIT];
         sw <= d[7:4];
      end
      // one idle edge so a following call never re-drives psel in this step
      @(posedge i_clk);
   endtask : apb
   initial begin
      logic [31:0] rd;
      logic err;
      int k;
      void'($urandom(32'h8e2ca001));
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      chk_on <= 1'b1;
      // every pin code, 0 to 9 for two output periods and 10 to 15 for 40 cycles, then random ones
      for (k = 0; k < 20; k++) begin
         code <= (k < 16) ? 4'(k) : 4'($urandom_range(15));
         repeat ((k < 10) ? (4 << k) + 8 : 40) @(posedge i_clk);
      end
      // software code overrides pins that keep moving
      repeat (6) begin
         code <= 4'($urandom_range(15));
         apb(1'b1, PFD_OFF_CTRL, {24'h0, 4'($urandom_range(15)), 4'h1}, 4'hf, rd, err);
         repeat (60) @(posedge i_clk);
         apb(1'b0, PFD_OFF_STATUS, 32'h0, 4'h0, rd, err);
         `CHK(rd[15:11], {sw > PFD_SEL_MAX, sw})
      end
      // refused accesses: lane 0 off, read-only word, unmapped word
      apb(1'b1, PFD_OFF_CTRL, 32'h0, 4'he, rd, err);
      apb(1'b0, PFD_OFF_CTRL, 32'h0, 4'h0, rd, err);
      `CHK(rd, {24'h0, sw, 3'h0, src})
      // thousands of cycles have run, so the counter has wrapped at least once
      apb(1'b0, PFD_OFF_EVENT, 32'h0, 4'h0, rd, err);
      `CHK({err, rd[PFD_EVT_WRAP_BIT]}, 2'b01)
      apb(1'b1, PFD_OFF_STATUS, 32'hffff_ffff, 4'hf, rd, err);
      `CHK(err, 1'b0)
      apb(1'b0, 12'h010, 32'h0, 4'h0, rd, err);
      `CHK({err, rd}, {1'b1, PFD_DATA_ZERO})
      // back to the pins, then a reset in mid-run
      apb(1'b1, PFD_OFF_CTRL, 32'h0, 4'h1, rd, err);
      code <= 4'h9;
      repeat (300) @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (1100) @(posedge i_clk);
      give_verdict();
   end
   // watchdog: the whole run needs about 6400 cycles
   initial begin
      #60000;
      num_errors++;
      give_verdict();
   end
endmodule : pfd_divider_tb
`default_nettype wire
